// ===== rtl/pcl_loader.sv
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`default_nettype none
module pcl_loader #(
    parameter int STATUS_CYCLES = pcl_pkg::STATUS_CYC,
    parameter int INIT_CYCLES = pcl_pkg::INIT_CYC,
    parameter int USER_CYCLES = pcl_pkg::USER_INIT_CYCLES,
    parameter logic [31:0] IMAGE_BITS = 32'h0000_1000
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic config_request_n_i,
    input wire logic config_status_n_i,
    output logic config_status_n_o,
    output logic config_status_n_oe_o,
    output logic load_complete_o,
    input wire logic config_clock_i,
    input wire logic config_data_i,
    input wire logic user_init_clock_i,
    input wire logic reconfig_strobe_i,
    input wire logic watchdog_reset_strobe_i,
    output logic user_mode_o,
    output logic watchdog_kick_o,
    input wire logic [7:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [7:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i
);
    typedef enum logic [2:0] {
        PCL_ST_RESET = 3'h0,
        PCL_ST_STATUS = 3'h1,
        PCL_ST_LOAD = 3'h2,
        PCL_ST_CU_WAIT = 3'h3,
        PCL_ST_INIT = 3'h4,
        PCL_ST_USER = 3'h5
    } pcl_state_t;

    pcl_axil_if rb();
    pcl_axil_slave u_slave (
        .clk_i(clk_i), .reset_n_i(reset_n_i),
        .awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
        .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
        .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
        .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
        .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
        .rb(rb)
    );

    pcl_state_t state, next_state;
    logic [31:0] timer, next_timer;
    logic [31:0] bit_count, next_bit_count;
    logic [31:0] shift, next_shift;
    logic [1:0] init_src, next_init_src;
    logic soft_reconfig, next_soft_reconfig;
    logic [3:0] strobe_cnt, next_strobe_cnt;
    logic [3:0] wd_cnt, next_wd_cnt;
    logic wd_kick, next_wd_kick;
    logic cclk_q, uclk_q, next_cclk_q, next_uclk_q;
    logic cclk_rise, uclk_rise, init_tick;

    assign cclk_rise = config_clock_i && !cclk_q;
    assign uclk_rise = user_init_clock_i && !uclk_q;
    // user and config sources advance the counter once per rise of their own clock; the oscillator source once per clk_i cycle
    always_comb begin
        unique case (init_src)
            pcl_pkg::PCL_SRC_USER: init_tick = uclk_rise;
            pcl_pkg::PCL_SRC_CFG: init_tick = cclk_rise;
            default: init_tick = 1'b1;
        endcase
    end

    // status pin is open drain: drive low only, release for high
    assign config_status_n_o = 1'b0;
    assign config_status_n_oe_o = (state == PCL_ST_RESET) || (state == PCL_ST_STATUS);
    assign load_complete_o = (state == PCL_ST_CU_WAIT) || (state == PCL_ST_INIT)
        || (state == PCL_ST_USER);
    assign user_mode_o = (state == PCL_ST_USER);
    assign watchdog_kick_o = wd_kick;

    always_comb begin
        next_state = state;
        next_timer = timer;
        next_bit_count = bit_count;
        next_shift = shift;
        next_cclk_q = config_clock_i;
        next_uclk_q = user_init_clock_i;
        next_init_src = init_src;
        next_soft_reconfig = 1'b0;
        next_strobe_cnt = strobe_cnt;
        next_wd_cnt = wd_cnt;
        next_wd_kick = 1'b0;
        // strobes count only if held the full 250 ns
        if (reconfig_strobe_i) begin
            if (strobe_cnt != 4'hF) next_strobe_cnt = strobe_cnt + 4'h1;
        end else begin
            next_strobe_cnt = 4'h0;
        end
        if (reconfig_strobe_i && strobe_cnt == 4'(pcl_pkg::STROBE_CYC - 1)) begin
            next_soft_reconfig = 1'b1;
        end
        if (watchdog_reset_strobe_i) begin
            if (wd_cnt != 4'hF) next_wd_cnt = wd_cnt + 4'h1;
        end else begin
            next_wd_cnt = 4'h0;
        end
        if (watchdog_reset_strobe_i && wd_cnt == 4'(pcl_pkg::STROBE_CYC - 1)) begin
            next_wd_kick = 1'b1;
        end
        if (rb.wr_en && rb.wr_addr == pcl_pkg::REG_CTRL) begin
            next_init_src = rb.wr_data[1:0] == 2'h3 ? init_src : rb.wr_data[1:0];
            next_soft_reconfig = next_soft_reconfig || rb.wr_data[8];
        end
        unique case (state)
            PCL_ST_RESET: begin
                // hold status low while request stays low; restart timing on release
                next_timer = 32'h0;
                next_bit_count = 32'h0;
                if (config_request_n_i) next_state = PCL_ST_STATUS;
            end
            PCL_ST_STATUS: begin
                // fixed 268 us pulse stays well under the 1506 us limit
                next_timer = timer + 32'h1;
                if (timer >= 32'(STATUS_CYCLES - 1)) begin
                    next_state = PCL_ST_LOAD;
                    next_timer = 32'h0;
                end
            end
            PCL_ST_LOAD: begin
                // a party holding status low keeps the load from starting
                if (cclk_rise && config_status_n_i) begin
                    next_shift = {shift[30:0], config_data_i};
                    next_bit_count = bit_count + 32'h1;
                    if (bit_count + 32'h1 >= IMAGE_BITS) next_state = PCL_ST_CU_WAIT;
                end
            end
            PCL_ST_CU_WAIT: begin
                // counted on clk_i: a host may stop config_clock after the last bit
                next_timer = timer + 32'h1;
                if (init_src != pcl_pkg::PCL_SRC_USER
                    || timer >= 32'(pcl_pkg::CU_DELAY_CYC - 1)) begin
                    next_state = PCL_ST_INIT;
                    next_timer = 32'h0;
                end
            end
            PCL_ST_INIT: begin
                if (init_tick) next_timer = timer + 32'h1;
                if (init_src == pcl_pkg::PCL_SRC_OSC) begin
                    if (timer >= 32'(INIT_CYCLES - 1)) next_state = PCL_ST_USER;
                end else if (timer >= 32'(USER_CYCLES)) begin
                    next_state = PCL_ST_USER;
                end
            end
            PCL_ST_USER: next_timer = 32'h0;
            default: next_state = PCL_ST_RESET;
        endcase
        // request low wins over everything, acts within one cycle
        if (!config_request_n_i || soft_reconfig) next_state = PCL_ST_RESET;
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state <= PCL_ST_RESET;
            timer <= 32'h0;
            bit_count <= 32'h0;
            shift <= 32'h0;
            cclk_q <= 1'b0;
            uclk_q <= 1'b0;
            init_src <= 2'h0;
            soft_reconfig <= 1'b0;
            strobe_cnt <= 4'h0;
            wd_cnt <= 4'h0;
            wd_kick <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            bit_count <= next_bit_count;
            shift <= next_shift;
            cclk_q <= next_cclk_q;
            uclk_q <= next_uclk_q;
            init_src <= next_init_src;
            soft_reconfig <= next_soft_reconfig;
            strobe_cnt <= next_strobe_cnt;
            wd_cnt <= next_wd_cnt;
            wd_kick <= next_wd_kick;
        end
    end

    always_comb begin
        rb.rd_hit = 1'b1;
        rb.wr_hit = (rb.wr_addr == pcl_pkg::REG_CTRL);
        unique case (rb.rd_addr)
            pcl_pkg::REG_CTRL: rb.rd_data = {30'h0, init_src};
            pcl_pkg::REG_STATUS: rb.rd_data = {26'h0, user_mode_o, load_complete_o,
                config_status_n_i, state};
            pcl_pkg::REG_BITCNT: rb.rd_data = bit_count;
            pcl_pkg::REG_SHIFT: rb.rd_data = shift;
            default: begin
                rb.rd_data = 32'h0;
                rb.rd_hit = 1'b0;
            end
        endcase
    end
endmodule // pcl_loader
`default_nettype wire

// ===== rtl/pcl_pkg.sv
`default_nettype none
package pcl_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_NS = 50;
    // device response times
    localparam int RESP_NS = 600;
    localparam int RESP_CYC = (RESP_NS / CLK_NS) < 1 ? 1 : (RESP_NS / CLK_NS);
    localparam int STATUS_MIN_US = 268;
    localparam int STATUS_MAX_US = 1506;
    localparam int STATUS_CYC = (STATUS_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int INIT_MIN_US = 175;
    localparam int INIT_MAX_US = 437;
    localparam int INIT_CYC = (INIT_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int USER_INIT_CYCLES = 8576;
    localparam int CU_DELAY_CYC = 4;
    localparam int STROBE_NS = 250;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int OSC_MIN_KHZ = 5300;
    localparam int OSC_TYP_KHZ = 7900;
    localparam int OSC_MAX_KHZ = 12500;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_BITCNT = 8'h08;
    localparam logic [7:0] REG_SHIFT = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    typedef enum logic [1:0] {
        PCL_SRC_OSC = 2'h0,
        PCL_SRC_USER = 2'h1,
        PCL_SRC_CFG = 2'h2
    } pcl_src_t;
endpackage
`default_nettype wire

// ===== rtl/pcl_axil_if.sv
`default_nettype none
interface pcl_axil_if;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_en;
    logic [7:0] rd_addr;
    logic rd_en;
    logic [31:0] rd_data;
    logic rd_hit;
    logic wr_hit;
    modport slave(output wr_addr, wr_data, wr_en, rd_addr, rd_en, input rd_data, rd_hit, wr_hit);
    modport core(input wr_addr, wr_data, wr_en, rd_addr, rd_en, output rd_data, rd_hit, wr_hit);
endinterface
`default_nettype wire

// ===== rtl/pcl_axil_slave.sv
`default_nettype none
module pcl_axil_slave (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [7:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    pcl_axil_if.slave rb
);
    logic aw_held, w_held, next_aw_held, next_w_held;
    logic [7:0] aw_q, next_aw_q;
    logic [31:0] w_q, next_w_q;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    // byte strobes are not decoded: every accepted write lands as a full word
    assign awready_o = !aw_held && !bvalid_o;
    assign wready_o = !w_held && !bvalid_o;
    assign arready_o = !rvalid_o;
    assign rb.wr_addr = aw_q;
    assign rb.wr_data = w_q;
    assign rb.wr_en = aw_held && w_held && !bvalid_o && (wstrb_i == 4'hF || 1'b1);
    assign rb.rd_addr = araddr_i;
    assign rb.rd_en = arvalid_i && arready_o;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_q = aw_q;
        next_w_q = w_q;
        next_bvalid = bvalid_o;
        next_bresp = bresp_o;
        next_rvalid = rvalid_o;
        next_rresp = rresp_o;
        next_rdata = rdata_o;
        if (awvalid_i && awready_o) begin
            next_aw_held = 1'b1;
            next_aw_q = awaddr_i;
        end
        if (wvalid_i && wready_o) begin
            next_w_held = 1'b1;
            next_w_q = wdata_i;
        end
        if (rb.wr_en) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = rb.wr_hit ? pcl_pkg::RESP_OKAY : pcl_pkg::RESP_DECERR;
        end else if (bvalid_o && bready_i) begin
            next_bvalid = 1'b0;
        end
        if (rb.rd_en) begin
            next_rvalid = 1'b1;
            next_rdata = rb.rd_data;
            next_rresp = rb.rd_hit ? pcl_pkg::RESP_OKAY : pcl_pkg::RESP_DECERR;
        end else if (rvalid_o && rready_i) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 32'h0000_0000;
            bvalid_o <= 1'b0;
            bresp_o <= 2'h0;
            rvalid_o <= 1'b0;
            rresp_o <= 2'h0;
            rdata_o <= 32'h0000_0000;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_q <= next_aw_q;
            w_q <= next_w_q;
            bvalid_o <= next_bvalid;
            bresp_o <= next_bresp;
            rvalid_o <= next_rvalid;
            rresp_o <= next_rresp;
            rdata_o <= next_rdata;
        end
    end
endmodule // pcl_axil_slave
`default_nettype wire

// ===== bench/pcl_chk.sv
`default_nettype none
module pcl_chk #(
    parameter int STATUS_CYCLES = 8,
    parameter int INIT_CYCLES = 8,
    parameter logic [31:0] IMAGE_BITS = 32'h0000_0010
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic config_request_n_i,
    input wire logic config_status_n_i,
    input wire logic config_status_n_o,
    input wire logic config_status_n_oe_o,
    input wire logic load_complete_o,
    input wire logic config_clock_i,
    input wire logic watchdog_reset_strobe_i,
    input wire logic user_mode_o,
    input wire logic watchdog_kick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] oe_cnt, rel_cnt, init_cnt, st_cnt;
    logic [31:0] bit_cnt;
    logic clk_d;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            oe_cnt <= 16'h0;
            rel_cnt <= 16'h0;
            init_cnt <= 16'h0;
            st_cnt <= 16'h0;
            bit_cnt <= 32'h0;
            clk_d <= 1'b0;
        end else begin
            oe_cnt <= config_status_n_oe_o ? oe_cnt + 16'h1 : 16'h0;
            rel_cnt <= (config_request_n_i && config_status_n_oe_o) ? rel_cnt + 16'h1 : 16'h0;
            init_cnt <= (load_complete_o && !user_mode_o) ? init_cnt + 16'h1 : 16'h0;
            st_cnt <= watchdog_reset_strobe_i ? st_cnt + 16'h1 : 16'h0;
            clk_d <= config_clock_i;
            // only rises seen while loading with the wire released count as data
            if (config_status_n_oe_o)
                bit_cnt <= 32'h0;
            else if (config_clock_i && !clk_d && config_status_n_i && !load_complete_o)
                bit_cnt <= bit_cnt + 32'h1;
        end
    end
    chk_req_pulls_low: assert property (!config_request_n_i |=> config_status_n_oe_o
        && !load_complete_o) else $error("request low not answered");
    chk_pull_clears_done: assert property (config_status_n_oe_o |-> !load_complete_o)
        else $error("load_complete high during status pulse");
    chk_pulse_width: assert property ($fell(config_status_n_oe_o)
        |-> oe_cnt >= STATUS_CYCLES) else $error("status pulse too short");
    chk_release_bound: assert property (rel_cnt <= STATUS_CYCLES + 2)
        else $error("status held low too long after request high");
    chk_drive_low: assert property (config_status_n_oe_o |-> !config_status_n_o)
        else $error("status driven high");
    chk_image_count: assert property ($rose(load_complete_o) |-> bit_cnt == IMAGE_BITS)
        else $error("load_complete at wrong bit count");
    chk_init_min: assert property ($rose(user_mode_o) |-> init_cnt >= INIT_CYCLES)
        else $error("user mode too early");
    chk_user_after_done: assert property (user_mode_o |-> load_complete_o)
        else $error("user mode without load_complete");
    chk_kick_strobe: assert property ($rose(watchdog_kick_o) |-> st_cnt >= 16'd5
        || $past(st_cnt) >= 16'd5) else $error("kick from short strobe");
    cover property ($rose(load_complete_o));
    cover property ($rose(user_mode_o));
    cover property ($rose(watchdog_kick_o));
endmodule // pcl_chk
bind pcl_loader pcl_chk #(
    .STATUS_CYCLES(STATUS_CYCLES),
    .INIT_CYCLES(INIT_CYCLES),
    .IMAGE_BITS(IMAGE_BITS)
) u_chk (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .config_request_n_i(config_request_n_i),
    .config_status_n_i(config_status_n_i),
    .config_status_n_o(config_status_n_o),
    .config_status_n_oe_o(config_status_n_oe_o),
    .load_complete_o(load_complete_o),
    .config_clock_i(config_clock_i),
    .watchdog_reset_strobe_i(watchdog_reset_strobe_i),
    .user_mode_o(user_mode_o),
    .watchdog_kick_o(watchdog_kick_o)
);
`default_nettype wire

// ===== bench/pcl_host.sv
`default_nettype none
module pcl_host (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic [15:0] image_i,
    input wire logic status_wire_i,
    input wire logic user_mode_i,
    output logic config_request_n_o,
    output logic config_clock_o,
    output logic config_data_o,
    output logic user_init_clock_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        config_request_n_o = 1'b1;
        config_clock_o = 1'b0;
        config_data_o = 1'b0;
        user_init_clock_o = 1'b0;
        busy_o = 1'b0;
    end
    // free-running, so far more than the minimum init cycles arrive
    always @(posedge clk_i) user_init_clock_o <= ~user_init_clock_o;
    always begin
        @(posedge clk_i);
        if (run_i === 1'b1) begin
            busy_o <= 1'b1;
            config_request_n_o <= 1'b0;
            repeat (40) @(posedge clk_i);
            config_request_n_o <= 1'b1;
            // watching status spares the long fixed wait after request rises
            for (int i = 0; i < 2000 && status_wire_i !== 1'b1; i++) @(posedge clk_i);
            repeat (40) @(posedge clk_i);
            // clock keeps running past the last bit; data toggles once unused
            for (int i = 0; i < 80 && user_mode_i !== 1'b1; i++) begin
                config_data_o <= (i < 16) ? image_i[15 - i] : ~config_data_o;
                repeat (2) @(posedge clk_i);
                config_clock_o <= 1'b1;
                repeat (2) @(posedge clk_i);
                config_clock_o <= 1'b0;
            end
            busy_o <= 1'b0;
        end
    end
endmodule // pcl_host
`default_nettype wire

// ===== bench/passive_config_init_timing_tb.sv
`default_nettype none
module passive_config_init_timing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic config_request_n_i, config_status_n_i, config_status_n_o, config_status_n_oe_o;
    logic load_complete_o, config_clock_i, config_data_i, user_init_clock_i, user_mode_o;
    logic reconfig_strobe_i = 1'b0, watchdog_reset_strobe_i = 1'b0;
    logic watchdog_kick_o, awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
    logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
    logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, d;
    logic [3:0] wstrb_i = 4'hF;
    logic [1:0] bresp_o, rresp_o, r;
    logic run = 1'b0;
    logic busy;
    logic [15:0] image = 16'h0;
    int fail_count = 0, n_tests = 0, kicks = 0, cycles = 0;
    // pull-up on the open-drain status wire
    assign config_status_n_i = config_status_n_oe_o ? config_status_n_o : 1'b1;
    always #25 clk_i = ~clk_i;
    pcl_loader #(.STATUS_CYCLES(8), .INIT_CYCLES(8), .USER_CYCLES(16),
        .IMAGE_BITS(32'h0000_0010)) u_dut (.*);
    pcl_host u_host (.clk_i(clk_i), .run_i(run), .image_i(image),
        .status_wire_i(config_status_n_i), .user_mode_i(user_mode_o),
        .config_request_n_o(config_request_n_i), .config_clock_o(config_clock_i),
        .config_data_o(config_data_i), .user_init_clock_o(user_init_clock_i), .busy_o(busy));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] exp_ctrl(input logic [1:0] held, input logic [31:0] v);
        return (v[1:0] == 2'h3) ? {30'h0, held} : {30'h0, v[1:0]};
    endfunction
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w, b;
        @(posedge clk_i);
        awaddr_i <= a;
        wdata_i <= v;
        awvalid_i <= 1'b1;
        wvalid_i <= 1'b1;
        bready_i <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge clk_i);
            aw = awvalid_i && awready_o;
            w = wvalid_i && wready_o;
            b = bvalid_o === 1'b1;
            r = bresp_o;
            @(posedge clk_i);
            if (aw) awvalid_i <= 1'b0;
            if (w) wvalid_i <= 1'b0;
        end
        bready_i <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic ar, v;
        @(posedge clk_i);
        araddr_i <= a;
        arvalid_i <= 1'b1;
        rready_i <= 1'b1;
        v = 1'b0;
        while (!v) begin
            @(negedge clk_i);
            ar = arvalid_i && arready_o;
            v = rvalid_o === 1'b1;
            d = rdata_o;
            r = rresp_o;
            @(posedge clk_i);
            if (ar) arvalid_i <= 1'b0;
        end
        rready_i <= 1'b0;
    endtask
    task automatic load(input logic [1:0] src);
        axi_wr(pcl_pkg::REG_CTRL, {30'h0, src});
        check({30'h0, r}, {30'h0, pcl_pkg::RESP_OKAY});
        axi_rd(pcl_pkg::REG_CTRL);
        check(d, exp_ctrl(2'h0, {30'h0, src}));
        image = 16'($urandom);
        @(posedge clk_i);
        run <= 1'b1;
        @(posedge clk_i);
        run <= 1'b0;
        repeat (3) @(negedge clk_i);
        check({30'h0, config_status_n_oe_o, load_complete_o}, 32'h2);
        while (busy === 1'b1) @(posedge clk_i);
        @(negedge clk_i);
        check({31'h0, user_mode_o}, 32'h1);
        axi_rd(pcl_pkg::REG_STATUS);
        check({29'h0, d[5:3]}, 32'h7);
        axi_rd(pcl_pkg::REG_SHIFT);
        check({16'h0, d[15:0]}, {16'h0, image});
        axi_rd(pcl_pkg::REG_BITCNT);
        check(d, 32'h10);
        $display("test load source %0d done", src);
    endtask
    task automatic pulse_wd(input int n, input int exp);
        int k0;
        k0 = kicks;
        @(posedge clk_i);
        watchdog_reset_strobe_i <= 1'b1;
        repeat (n) @(posedge clk_i);
        watchdog_reset_strobe_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check(32'(kicks - k0), 32'(exp));
        $display("test watchdog strobe %0d done", n);
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (watchdog_kick_o === 1'b1) kicks++;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(91));
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
        axi_rd(8'h10);
        check(d, 32'h0);
        check({30'h0, r}, {30'h0, pcl_pkg::RESP_DECERR});
        axi_wr(pcl_pkg::REG_SHIFT, 32'($urandom));
        check({30'h0, r}, {30'h0, pcl_pkg::RESP_DECERR});
        axi_wr(pcl_pkg::REG_CTRL, 32'h0000_0003);
        check({30'h0, r}, {30'h0, pcl_pkg::RESP_OKAY});
        axi_rd(pcl_pkg::REG_CTRL);
        check(d, exp_ctrl(2'h0, 32'h0000_0003));
        $display("test register map done");
        for (int s = 0; s < 3; s++) load(2'(s));
        pulse_wd(4, 0);
        pulse_wd(5, 1);
        @(posedge clk_i);
        reconfig_strobe_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        reconfig_strobe_i <= 1'b0;
        repeat (3) @(negedge clk_i);
        check({31'h0, user_mode_o}, 32'h0);
        load(2'h0);
        axi_wr(pcl_pkg::REG_CTRL, 32'h0000_0100);
        repeat (3) @(negedge clk_i);
        check({30'h0, config_status_n_oe_o, user_mode_o}, 32'h2);
        $display("test reconfigure done");
        complete_run();
    end
endmodule // passive_config_init_timing_tb
`default_nettype wire
